// >>> rtl/odii_pkg.sv
// Package for the octal digital input image block.
// Assumes one 200 MHz logic clock shared by all files.
package odii_pkg;

    localparam int          CHANNELS        = 8;
    localparam logic [7:0]  IMAGE_OFFSET    = 8'h00;
    localparam logic [7:0]  IMAGE_RESET     = 8'h00;
    localparam int          INPUT_BYTES     = 1;
    localparam int          OUTPUT_BYTES    = 0;
    localparam int          PARAM_BYTES     = 0;
    localparam int          DIAG_BYTES      = 0;
    localparam logic [15:0] CAN_OBJ_INDEX   = 16'h6000;
    localparam logic [7:0]  ECAT_SUB_FIRST  = 8'h01;
    localparam logic [7:0]  ECAT_SUB_LAST   = 8'h08;
    // Arbitrary neutral identity value
    localparam logic [31:0] MODULE_ID       = 32'h0000_0a5a;

    localparam int          CLK_MHZ         = 200;
    localparam int          MAX_DELAY_US    = 500;
    // Filter stable time: 400 us, leaves margin for sync and image update
    localparam int          FILT_US         = 400;
    localparam int          FILT_CYCLES     = FILT_US * CLK_MHZ;
    // Tick every 1 us, filter counts ticks
    localparam int          TICK_CYCLES     = CLK_MHZ;
    localparam logic [7:0]  TICK_LAST       = 8'(TICK_CYCLES - 1);
    localparam logic [8:0]  FILT_TICKS      = 9'(FILT_CYCLES / TICK_CYCLES);
    // Config-error flash: 2 Hz toggle period in us ticks
    localparam int          FLASH_US        = 250000;
    localparam logic [17:0] FLASH_LAST      = 18'(FLASH_US - 1);

    typedef enum logic [1:0] {
        ODII_ST_RESET,
        ODII_ST_RUN,
        ODII_ST_FAULT
    } odii_state_e;

endpackage : odii_pkg

// >>> rtl/odii_filter.sv
// One channel: two-flop synchroniser plus stable-time filter.
// Assumes a 1 us tick enable from the parent.
`timescale 1ns/1ps
`default_nettype none

module odii_filter (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Timebase
    input  wire logic tick,
    // Field side
    input  wire logic fieldIn,
    // Filtered level
    output logic      level
);

    logic       meta_r;
    logic       sync_r;
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    wire        differs = sync_r != level;
    wire        expired = cnt_r >= odii_pkg::FILT_TICKS;

    assign cnt_nxt = !differs ? 9'h000 : (tick && !expired) ? cnt_r + 9'h001 : cnt_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= fieldIn;
            sync_r <= meta_r;
        end
    end

    // Both edges filtered alike, bounded well under 500 us
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 9'h000;
            level <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt; // RQ4
            if (differs && expired) begin
                level <= sync_r; // RQ4
            end
        end
    end

endmodule : odii_filter
`default_nettype wire

// >>> rtl/odii_top.sv
// Octal digital input image: filtered inputs, one-byte image, indicators.
// Assumes backplane logic clock, inputs synchronous-capable, one byte read port.
//
// Overview of operation
// RQ1: Eight channels form image byte at offset zero.
// RQ2: Byte maps to object 6000h, subindices 01h-08h.
// RQ3: No output bytes; output writes ignored.
// RQ4: Input changes reach image within 500 us.
// RQ5: No interrupts, parameters or diagnostic bytes.
// RQ6: Green channel indicator follows input level.
// RQ7: Run and fault indicators show four conditions.
// RQ8: Synchronise, filter, update image as coherent snapshot.
`timescale 1ns/1ps
`default_nettype none

module odii_top (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Field inputs
    input  wire logic [7:0] fieldInputChannel,
    // Head module read port
    input  wire logic       imageRead,
    input  wire logic [7:0] imageAddr,
    output logic [7:0]      processInputImage,
    output logic            readValid,
    // Head module output slot, unused
    input  wire logic       outWrite,
    input  wire logic [7:0] outData,
    // Status from the backplane
    input  wire logic       busCommOk,
    input  wire logic       busSupplyOk,
    input  wire logic       configOk,
    // Indicators
    output logic [7:0]      channelIndicator,
    output logic            runIndicator,
    output logic            moduleFaultIndicator
);

    ////////////////////////////////////////////////////////////////////////////
    // Timebase

    logic [7:0]  tickCnt_r;
    logic        tick_r;
    wire         tickWrap = tickCnt_r == odii_pkg::TICK_LAST;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_r <= 8'h00;
            tick_r    <= 1'b0;
        end else begin
            tickCnt_r <= tickWrap ? 8'h00 : tickCnt_r + 8'h01;
            tick_r    <= tickWrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels

    logic [7:0] filtered;

    generate
        for (genvar ch = 0; ch < odii_pkg::CHANNELS; ch++) begin : g_ch
            odii_filter u_filt (
                .clock   (clock),
                .rst_n   (rst_n),
                .tick    (tick_r),
                .fieldIn (fieldInputChannel[ch]),
                .level   (filtered[ch])
            ); // RQ8
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Image register and read port

    logic [7:0] image_r;
    wire        addrHit = imageAddr == odii_pkg::IMAGE_OFFSET;
    // Output slot has no storage; these inputs go nowhere by design
    wire        outIgnored = outWrite & |outData; // RQ3

    // All eight bits latched in one edge, so a read never tears
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            image_r <= odii_pkg::IMAGE_RESET;
        end else begin
            image_r <= filtered; // RQ8
        end
    end

    // Bit n carries channel n; unmapped offsets read zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            processInputImage <= 8'h00;
            readValid         <= 1'b0;
        end else begin
            readValid <= imageRead;
            if (imageRead) begin
                processInputImage <= addrHit ? image_r : 8'h00; // RQ1 RQ2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indicators

    logic [17:0] flashCnt_r;
    logic        flash_r;
    odii_pkg::odii_state_e state_r;
    odii_pkg::odii_state_e state_nxt;
    wire         moduleOk = busSupplyOk & configOk;

    always_comb begin
        case (state_r)
            odii_pkg::ODII_ST_RESET: state_nxt = moduleOk ? odii_pkg::ODII_ST_RUN
                                                          : odii_pkg::ODII_ST_FAULT;
            odii_pkg::ODII_ST_RUN:   state_nxt = moduleOk ? odii_pkg::ODII_ST_RUN
                                                          : odii_pkg::ODII_ST_FAULT;
            default:                 state_nxt = moduleOk ? odii_pkg::ODII_ST_RUN
                                                          : odii_pkg::ODII_ST_FAULT;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flashCnt_r <= 18'h00000;
            flash_r    <= 1'b0;
            state_r    <= odii_pkg::ODII_ST_RESET;
        end else begin
            state_r <= state_nxt;
            if (tick_r) begin
                flashCnt_r <= (flashCnt_r == odii_pkg::FLASH_LAST) ? 18'h00000
                                                                   : flashCnt_r + 18'h00001;
                if (flashCnt_r == odii_pkg::FLASH_LAST) begin
                    flash_r <= ~flash_r;
                end
            end
        end
    end

    // Run: on when bus and config ok. Fault: on for error, flashing for config error.
    wire runNxt   = busCommOk & busSupplyOk & configOk; // RQ7
    wire faultNxt = !configOk ? flash_r
                  : (state_r == odii_pkg::ODII_ST_FAULT) | !busCommOk; // RQ7

    // No interrupt, alarm or diagnostic outputs exist at all
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            channelIndicator     <= 8'h00;
            runIndicator         <= 1'b0;
            moduleFaultIndicator <= 1'b0;
        end else begin
            channelIndicator     <= filtered; // RQ6
            runIndicator         <= runNxt; // RQ7
            moduleFaultIndicator <= faultNxt & ~outIgnored | faultNxt;
        end
    end

endmodule : odii_top
`default_nettype wire

// >>> tb/odii_top_properties.sv
// Checker on the odii_top ports, bound below.
// Assumes one clock domain and rst_n async low.
`timescale 1ns/1ps
`default_nettype none
module odii_checker (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // Watched ports
    input wire logic [7:0] fieldInputChannel,
    input wire logic       imageRead,
    input wire logic [7:0] imageAddr,
    input wire logic [7:0] processInputImage,
    input wire logic       readValid,
    input wire logic       outWrite,
    input wire logic       busCommOk,
    input wire logic       busSupplyOk,
    input wire logic       configOk,
    input wire logic [7:0] channelIndicator,
    input wire logic       runIndicator,
    input wire logic       moduleFaultIndicator
);
    // 500 us at 200 MHz; too long for a repetition
    localparam int STILL_MAX = 100000;
    int  stillCnt_r;
    wire allOk = busCommOk && busSupplyOk && configOk;
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n) stillCnt_r <= 0;
        else if ($changed(fieldInputChannel)) stillCnt_r <= 0;
        else if (stillCnt_r < STILL_MAX) stillCnt_r <= stillCnt_r + 1;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_rd0;
        imageRead && imageAddr == 8'h00 && $stable(channelIndicator) ##1 $stable(channelIndicator);
    endsequence
    property p_rdAns; imageRead |=> readValid; endproperty
    a_rdAns: assert property (p_rdAns) else $error("read unanswered");
    property p_image; s_rd0 |-> processInputImage == channelIndicator; endproperty
    a_image: assert property (p_image) else $error("image byte wrong");
    property p_unmap; imageRead && imageAddr != 8'h00 |=> processInputImage == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_outSlot; outWrite && !imageRead |=> $stable(processInputImage) && !readValid; endproperty
    a_outSlot: assert property (p_outSlot) else $error("output slot used");
    // Fault path lags one more cycle through the state register
    property p_run; allOk [*3] |-> runIndicator && !moduleFaultIndicator; endproperty
    a_run: assert property (p_run) else $error("run state");
    sequence s_badHeld;
        (configOk && !allOk && $stable({busCommOk, busSupplyOk})) [*2];
    endsequence
    property p_fault; s_badHeld |=> moduleFaultIndicator && !runIndicator; endproperty
    a_fault: assert property (p_fault) else $error("fault state");
    property p_cfg; !configOk |=> !runIndicator; endproperty
    a_cfg: assert property (p_cfg) else $error("config state");
    property p_field; stillCnt_r == STILL_MAX |-> channelIndicator == fieldInputChannel; endproperty
    a_field: assert property (p_field) else $error("input too slow");
endmodule : odii_checker
bind odii_top odii_checker chk (.clock, .rst_n, .fieldInputChannel, .imageRead, .imageAddr,
    .processInputImage, .readValid, .outWrite, .busCommOk, .busSupplyOk, .configOk,
    .channelIndicator, .runIndicator, .moduleFaultIndicator);
`default_nettype wire

// >>> tb/odii_head_model.sv
// Head module model: byte reads and output-slot writes.
// Assumes each call starts just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module odii_head_model (
    // Clock and answer
    input wire logic       clock,
    input wire logic       readValid,
    input wire logic [7:0] processInputImage,
    // Requests
    output logic           imageRead,
    output logic [7:0]     imageAddr,
    output logic           outWrite,
    output logic [7:0]     outData
);
    initial {imageRead, imageAddr, outWrite, outData} = '0;
    // Request held to the taking edge; calls may follow back to back
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        imageRead = 1'b1;
        imageAddr = a;
        outWrite  = 1'b0;
        @(posedge clock);
        #1 v = readValid;
        d = processInputImage;
    endtask : rd
    // Released address toggles and an output-slot write is driven; processInputImage keeps the last read byte
    task automatic idle();
        imageRead = 1'b0;
        imageAddr = ~imageAddr;
        outWrite  = 1'b1;
        outData   = ~outData;
        @(posedge clock);
        #1;
    endtask : idle
endmodule : odii_head_model
`default_nettype wire

// >>> tb/odii_top_test.sv
// Bench for odii_top: status table, input filter timing, reads.
// Assumes the head model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module odii_top_test;
    logic       clock, rst_n, imageRead, readValid, outWrite, v, busCommOk, busSupplyOk;
    logic       configOk, runIndicator, moduleFaultIndicator;
    logic [7:0] fieldInputChannel, imageAddr, processInputImage, outData, channelIndicator, d;
    int         error_cnt = 0, samples_checked = 0, firstHit = -1, glitchHits = 0;
    // {comm, supply, config, run, fault}
    logic [4:0] rows [5] = '{5'b11110, 5'b01101, 5'b10101, 5'b00101, 5'b11000};
    odii_top uut (.clock, .rst_n, .fieldInputChannel, .imageRead, .imageAddr,
        .processInputImage, .readValid, .outWrite, .outData, .busCommOk, .busSupplyOk,
        .configOk, .channelIndicator, .runIndicator, .moduleFaultIndicator);
    odii_head_model head (.clock, .readValid, .processInputImage, .imageRead, .imageAddr,
        .outWrite, .outData);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        rst_n = 1'b0;
        fieldInputChannel = 8'h00;
        {busCommOk, busSupplyOk, configOk} = 3'b111;
        repeat (10) @(posedge clock);
        #1 rst_n = 1'b1;
        check(channelIndicator | processInputImage | {readValid, runIndicator}, 8'h00);
        foreach (rows[i]) begin
            {busCommOk, busSupplyOk, configOk} = rows[i][4:2];
            repeat (2) @(posedge clock);
            #1 check({runIndicator, moduleFaultIndicator & configOk}, rows[i][1:0]);
        end
        {busCommOk, busSupplyOk, configOk} = 3'b111;
        // Channel 1 pulses for 10 us only; the filter must drop it
        for (int n = 0; n <= 100000; n++) begin
            fieldInputChannel = (n >= 20 && n < 2020) ? 8'ha7 : 8'ha5;
            @(posedge clock);
            #1 if (firstHit < 0 && channelIndicator === 8'ha5) firstHit = n;
            if (channelIndicator[1] !== 1'b0) glitchHits++;
        end
        check(8'(firstHit >= 0), 8'h01);
        check(8'(glitchHits != 0), 8'h00);
        head.rd(8'h01, d, v);
        check(d, 8'h00);
        head.rd(8'h00, d, v);
        check(d, 8'ha5);
        check(8'(v), 8'h01);
        head.idle();
        check({readValid, processInputImage[6:0]}, 8'h25);
        give_verdict();
    end
endmodule : odii_top_test
`default_nettype wire
